// file: inc/disp_ctrl_pkg.sv
// constants for the display enable / attribute control block
// assumes a host port with byte registers and a per-frame tick from panel timing
`default_nettype none

package disp_ctrl_pkg;

  // register map
  localparam logic [15:0] ADDR_DISP_EN = 16'h8009;
  localparam logic [15:0] ADDR_ATTR    = 16'h800a;
  localparam logic [7:0]  DISP_EN_RST  = 8'h00;
  localparam logic [7:0]  ATTR_RST     = 8'h00;
  localparam int          DISP_EN_BIT  = 0;

  // attribute field positions (lsb of each two-bit field)
  localparam int FLD_CURSOR = 0;
  localparam int FLD_BLK1   = 2;
  localparam int FLD_BLK2   = 4;
  localparam int FLD_BLK3   = 6;

  // field codes
  localparam logic [1:0] ATTR_BLANK  = 2'b00;
  localparam logic [1:0] ATTR_STEADY = 2'b01;
  localparam logic [1:0] ATTR_SLOW   = 2'b10;
  localparam logic [1:0] ATTR_FAST   = 2'b11;

  // blink periods in frames
  localparam int FRAME_CNT_W    = 6;
  localparam int BLK_SLOW_DIV   = 32;
  localparam int BLK_FAST_DIV   = 4;
  localparam int CUR_SLOW_DIV   = 32;
  localparam int CUR_SLOWER_DIV = 64;
  localparam int CUR_DUTY_PCT   = 70;

  // cursor on-time in frames, rounded down so it never exceeds 70 percent
  localparam logic [FRAME_CNT_W-1:0] CUR_ON_32 =
    FRAME_CNT_W'((CUR_SLOW_DIV * CUR_DUTY_PCT) / 100);
  localparam logic [FRAME_CNT_W-1:0] CUR_ON_64 =
    FRAME_CNT_W'((CUR_SLOWER_DIV * CUR_DUTY_PCT) / 100);

endpackage : disp_ctrl_pkg

`default_nettype wire

// file: hdl/frame_blink_counter.sv
// free-running frame counter feeding every blink phase
// assumes frame_tick_i is a one-cycle pulse once per panel frame
`timescale 1ns/1ps
`default_nettype none

module frame_blink_counter
  import disp_ctrl_pkg::*;
#(
  parameter int CNT_W = FRAME_CNT_W
)
(
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  // frame pulse in, count out
  input  wire logic             frame_tick_i,
  output logic      [CNT_W-1:0] frame_cnt_o
);

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  // wraps naturally, so every period is a power-of-two number of frames
  always_comb
  begin
    cnt_next = cnt_reg;
    if (frame_tick_i)
    begin
      cnt_next = cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_reg <= '0;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end

  assign frame_cnt_o = cnt_reg;

endmodule // frame_blink_counter

`default_nettype wire

// file: hdl/display_enable_attribute_ctrl.sv
// display master enable, layer/cursor blink attributes and cursor side
// effects of host memory accesses
// assumes host strobes are one-cycle pulses synchronous to clock_i and that
// the panel timing logic supplies one frame tick per frame
`timescale 1ns/1ps
`default_nettype none

module display_enable_attribute_ctrl
  import disp_ctrl_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  // clock and reset
  input  wire logic              clock_i,
  input  wire logic              nrst_i,
  // direct register access
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  input  wire logic [7:0]        reg_wdata_i,
  output logic      [7:0]        reg_rdata_o,
  output logic                   reg_rvalid_o,
  // indirect display switch command with its parameter byte
  input  wire logic              display_switch_command_i,
  input  wire logic              display_switch_on_i,
  input  wire logic [7:0]        display_switch_param_i,
  // host display memory accesses
  input  wire logic              mem_wr_i,
  input  wire logic              mem_rd_i,
  // system state
  input  wire logic              power_save_i,
  input  wire logic              dual_panel_i,
  input  wire logic              frame_tick_i,
  // visibility towards the pixel pipeline
  output logic      [3:0]        block_visible_o,
  output logic                   cursor_visible_o,
  output logic                   cursor_advance_o,
  output logic                   lcd_off_o
);

  // decode of one screen block field against the frame count
  function automatic logic block_on(input logic [1:0] fld,
                                    input logic [FRAME_CNT_W-1:0] cnt);
    logic [FRAME_CNT_W-1:0] slow_m;
    logic [FRAME_CNT_W-1:0] fast_m;
    slow_m = FRAME_CNT_W'(BLK_SLOW_DIV - 1);
    fast_m = FRAME_CNT_W'(BLK_FAST_DIV - 1);
    unique case (fld)
      ATTR_BLANK:  block_on = 1'b0;
      ATTR_STEADY: block_on = 1'b1;
      // half period on, half off
      ATTR_SLOW:   block_on = (cnt & slow_m) < FRAME_CNT_W'(BLK_SLOW_DIV / 2);
      ATTR_FAST:   block_on = (cnt & fast_m) < FRAME_CNT_W'(BLK_FAST_DIV / 2);
    endcase
  endfunction

  // decode of the cursor field; blinking cursor is on 22 of 32 or 44 of 64 frames, just under 70 percent
  function automatic logic cursor_on(input logic [1:0] fld,
                                     input logic [FRAME_CNT_W-1:0] cnt);
    logic [FRAME_CNT_W-1:0] m32;
    m32 = FRAME_CNT_W'(CUR_SLOW_DIV - 1);
    unique case (fld)
      ATTR_BLANK:  cursor_on = 1'b0;
      ATTR_STEADY: cursor_on = 1'b1;
      ATTR_SLOW:   cursor_on = (cnt & m32) < CUR_ON_32;
      ATTR_FAST:   cursor_on = cnt < CUR_ON_64;
    endcase
  endfunction

  // shared frame count
  // one counter serves all fields so blinking blocks stay in phase
  logic [FRAME_CNT_W-1:0] frame_cnt;

  frame_blink_counter #(
    .CNT_W        (FRAME_CNT_W)
  ) u_frame_cnt (
    .clock_i      (clock_i),
    .nrst_i       (nrst_i),
    .frame_tick_i (frame_tick_i),
    .frame_cnt_o  (frame_cnt)
  );

  // register state
  logic       disp_en_reg;
  logic       disp_en_next;
  logic [7:0] attr_reg;
  logic [7:0] attr_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       rvalid_next;

  // register writes, command load, power save and memory side effects;
  // later assignments win, so the order encodes priority
  always_comb
  begin
    disp_en_next = disp_en_reg;
    attr_next    = attr_reg;
    if (reg_wr_i && reg_addr_i == ADDR_DISP_EN)
    begin
      disp_en_next = reg_wdata_i[DISP_EN_BIT];
    end
    if (reg_wr_i && reg_addr_i == ADDR_ATTR)
    begin
      attr_next = reg_wdata_i;
    end
    if (display_switch_command_i)
    begin
      attr_next    = display_switch_param_i;
      disp_en_next = display_switch_on_i;
    end
    // hidden cursor comes back steady on a memory write; a read leaves it
    if (mem_wr_i && attr_next[FLD_CURSOR +: 2] == ATTR_BLANK)
    begin
      attr_next[FLD_CURSOR +: 2] = ATTR_STEADY;
    end
    // power save has the last word so software cannot keep the panel on
    if (power_save_i)
    begin
      disp_en_next = 1'b0;
    end
  end

  // read port answers one cycle after the strobe; unmapped reads give zero
  // unused enable bits read back as zero so software can mask nothing
  always_comb
  begin
    rdata_next  = '0;
    rvalid_next = reg_rd_i;
    if (reg_rd_i)
    begin
      if (reg_addr_i == ADDR_DISP_EN)
      begin
        rdata_next[DISP_EN_BIT] = disp_en_reg;
      end
      else if (reg_addr_i == ADDR_ATTR)
      begin
        rdata_next = attr_reg;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      disp_en_reg <= DISP_EN_RST[DISP_EN_BIT];
      attr_reg    <= ATTR_RST;
      rdata_reg   <= '0;
      rvalid_reg  <= 1'b0;
    end
    else
    begin
      disp_en_reg <= disp_en_next;
      attr_reg    <= attr_next;
      rdata_reg   <= rdata_next;
      rvalid_reg  <= rvalid_next;
    end
  end

  // visibility state
  logic [3:0] blk_vis_reg;
  logic [3:0] blk_vis_next;
  logic       cur_vis_reg;
  logic       cur_vis_next;
  logic       adv_reg;
  logic       adv_next;
  logic       off_reg;
  logic       off_next;

  // visibility decode from the stored attributes; master enable gates block and cursor visibility, not the advance
  always_comb
  begin
    blk_vis_next[0] = block_on(attr_reg[FLD_BLK1 +: 2], frame_cnt);
    blk_vis_next[1] = block_on(attr_reg[FLD_BLK2 +: 2], frame_cnt);
    blk_vis_next[2] = block_on(attr_reg[FLD_BLK3 +: 2], frame_cnt);
    // fourth block has no field of its own and exists only in dual panel
    blk_vis_next[3] = dual_panel_i &&
                      block_on(attr_reg[FLD_BLK2 +: 2], frame_cnt);
    cur_vis_next    = cursor_on(attr_reg[FLD_CURSOR +: 2], frame_cnt);
    if (!disp_en_reg)
    begin
      blk_vis_next = '0;
      cur_vis_next = 1'b0;
    end
    // both kinds of memory access move the cursor on by one location
    adv_next = mem_wr_i || mem_rd_i;
    // lcd pins go to their power-save levels while the display is off
    off_next = !disp_en_reg;
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      blk_vis_reg <= '0;
      cur_vis_reg <= 1'b0;
      adv_reg     <= 1'b0;
      // panel pins sit at power-save levels until software enables
      off_reg     <= !DISP_EN_RST[DISP_EN_BIT];
    end
    else
    begin
      blk_vis_reg <= blk_vis_next;
      cur_vis_reg <= cur_vis_next;
      adv_reg     <= adv_next;
      off_reg     <= off_next;
    end
  end

  // outputs straight from flops
  assign reg_rdata_o      = rdata_reg;
  assign reg_rvalid_o     = rvalid_reg;
  assign block_visible_o  = blk_vis_reg;
  assign cursor_visible_o = cur_vis_reg;
  assign cursor_advance_o = adv_reg;
  assign lcd_off_o        = off_reg;

endmodule // display_enable_attribute_ctrl

`default_nettype wire

// file: verification/frame_source.sv
// frame source standing in for the panel timing logic
// assumes the controller clock; it runs through reset as a panel would
`timescale 1ns/1ps
`default_nettype none

module frame_source #(parameter int PERIOD = 8)
(
  // clock in, frame pulse out
  input  wire logic clock_i,
  output logic      frame_tick_o
);
  // one-cycle tick per frame, launched just after an edge
  // short frames keep the blink runs brief
  initial
  begin
    frame_tick_o = 1'b0;
    forever
    begin
      repeat (PERIOD - 1) @(posedge clock_i);
      frame_tick_o <= 1'b1;
      @(posedge clock_i);
      frame_tick_o <= 1'b0;
    end
  end
endmodule // frame_source

`default_nettype wire

// file: verification/disp_ctrl_asserts.sv
// port assertions for the display enable and attribute block
// assumes one clock domain; bound onto every instance of the block
`timescale 1ns/1ps
`default_nettype none

module disp_ctrl_asserts
(
  // clock, reset and host side
  input wire logic       clock_i,
  input wire logic       nrst_i,
  input wire logic       reg_rd_i,
  input wire logic       mem_wr_i,
  input wire logic       mem_rd_i,
  input wire logic       power_save_i,
  input wire logic       dual_panel_i,
  // outputs of the block
  input wire logic       reg_rvalid_o,
  input wire logic [3:0] block_visible_o,
  input wire logic       cursor_visible_o,
  input wire logic       cursor_advance_o,
  input wire logic       lcd_off_o
);
  // everything here lives in the one clock domain
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  a_off_blank: assert property (lcd_off_o |-> !block_visible_o &&
    !cursor_visible_o) else $error("shown while display off");
  a_rd_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  a_rd_single: assert property (reg_rvalid_o |-> $past(reg_rd_i))
    else $error("answer without read");
  a_mem_advance: assert property ((mem_wr_i || mem_rd_i) |=>
    cursor_advance_o) else $error("cursor did not advance");
  a_adv_cause: assert property (cursor_advance_o |->
    $past(mem_wr_i) || $past(mem_rd_i)) else $error("stray advance");
  a_ps_blank: assert property (power_save_i |-> ##2 lcd_off_o)
    else $error("display on in power save");
  // dual panel level is sampled before it reaches the outputs
  a_blk4_single: assert property (!$past(dual_panel_i) &&
    !$past(dual_panel_i, 2) |-> !block_visible_o[3])
    else $error("fourth block shown on single panel");
  a_blk4_follow: assert property ($past(dual_panel_i) &&
    $past(dual_panel_i, 2) |-> block_visible_o[3] == block_visible_o[1])
    else $error("fourth block differs from second");
endmodule // disp_ctrl_asserts

bind display_enable_attribute_ctrl disp_ctrl_asserts disp_ctrl_asserts_inst (
  .clock_i(clock_i), .nrst_i(nrst_i), .reg_rd_i(reg_rd_i),
  .mem_wr_i(mem_wr_i), .mem_rd_i(mem_rd_i), .power_save_i(power_save_i),
  .dual_panel_i(dual_panel_i), .reg_rvalid_o(reg_rvalid_o),
  .block_visible_o(block_visible_o), .cursor_visible_o(cursor_visible_o),
  .cursor_advance_o(cursor_advance_o), .lcd_off_o(lcd_off_o));

`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the display enable and attribute block
// assumes the frame source model paces the frames
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import disp_ctrl_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [7:0]  wd = 8'h00;
  logic [7:0]  par = 8'h00;
  logic        wr = 1'b0, rd = 1'b0, cmd = 1'b0, on = 1'b0;
  logic        mwr = 1'b0, mrd = 1'b0, ps = 1'b0, dual = 1'b0;
  logic [7:0]  rdat;
  logic [3:0]  blk, smp, old;
  logic        rv, adv, off, cur, tick;
  logic [31:0] seed = 32'h0851, onc, tgc;
  logic [7:0]  expq[$];
  logic [7:0]  lay_a[5] = '{8'h55, 8'h40, 8'h10, 8'h04, 8'h01};
  logic [5:0]  lay_e[5] = '{6'h1f, 6'h04, 6'h0a, 6'h01, 6'h10};
  int          mismatches = 0, checks = 0;
  int          advances = 0;

  frame_source frame_source_inst (.clock_i(clk), .frame_tick_o(tick));
  display_enable_attribute_ctrl display_enable_attribute_ctrl_inst (
    .clock_i(clk), .nrst_i(rst_n), .reg_addr_i(adr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat),
    .reg_rvalid_o(rv), .display_switch_command_i(cmd),
    .display_switch_on_i(on), .display_switch_param_i(par),
    .mem_wr_i(mwr), .mem_rd_i(mrd), .power_save_i(ps),
    .dual_panel_i(dual), .frame_tick_i(tick), .block_visible_o(blk),
    .cursor_visible_o(cur), .cursor_advance_o(adv), .lcd_off_o(off));

  // 250 MHz clock
  always #2 clk = ~clk;

  task automatic chk(logic [31:0] g, logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask

  // strobe dropped a full cycle before the next request can rise
  task automatic bus(logic w, logic [15:0] a, logic [7:0] d);
    if (!w) expq.push_back(d);
    {adr, wd, wr, rd} = {a, d, w, !w};
    @(negedge clk);
    {wr, rd} = 2'b00;
    @(negedge clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
    @(negedge clk);
  endtask

  task automatic vis(logic [5:0] e);
    repeat (2) @(negedge clk);
    chk(32'({off, cur, blk}), 32'(e));
  endtask

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // read answers are taken against the oldest note; none left fails
  always @(negedge clk)
    if (rv === 1'b1)
      chk(32'(rdat), expq.size() ? 32'(expq.pop_front()) : 32'hx);

  // each memory access must show exactly one advance pulse
  always @(negedge clk)
    if (adv === 1'b1)
      advances++;

  // watchdog sized well past the few microseconds the tests need
  initial
  begin
    #40000;
    mismatches++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    repeat (8) @(negedge clk);
    chk(32'({off, cur, blk}), 32'h20);
    rst_n = 1'b1;
    bus(0, ADDR_DISP_EN, DISP_EN_RST);
    bus(0, ADDR_ATTR, ATTR_RST);
    bus(1, 16'h800b, 8'hff);
    bus(0, 16'h800b, 8'h00);
    bus(1, ADDR_DISP_EN, 8'hff);
    bus(0, ADDR_DISP_EN, 8'h01);
    repeat (4)
    begin
      seed = lfsr(seed);
      bus(1, ADDR_ATTR, seed[7:0]);
      bus(0, ADDR_ATTR, seed[7:0]);
    end
    dual = 1'b1;
    foreach (lay_a[i])
    begin
      bus(1, ADDR_ATTR, lay_a[i]);
      vis(lay_e[i]);
    end
    dual = 1'b0;
    bus(1, ADDR_ATTR, 8'h55);
    vis(6'h17);
    bus(1, ADDR_DISP_EN, 8'h00);
    vis(6'h20);
    $display("test layout done");
    // 64 frames cover every blink period whole, whatever the phase
    bus(1, ADDR_DISP_EN, 8'h01);
    for (int m = 0; m < 2; m++)
    begin
      bus(1, ADDR_ATTR, m ? 8'h27 : 8'h3a);
      {onc, tgc} = 64'h0;
      for (int f = 0; f <= 64; f++)
      begin
        @(posedge tick);
        repeat (3) @(negedge clk);
        smp = {cur, blk[0], blk[1], blk[2]};
        for (int k = 0; k < 4; k++)
        begin
          onc[8*k +: 8] += 8'(f > 0 && smp[k]);
          tgc[8*k +: 8] += 8'(f > 0 && smp[k] != old[k]);
        end
        old = smp;
      end
      chk(onc, m ? 32'h2c40_2000 : 32'h2c20_2000);
      chk(tgc, m ? 32'h0200_0400 : 32'h0404_2000);
    end
    $display("test blink done");
    bus(1, ADDR_ATTR, 8'h54);
    pulse(mrd);
    bus(0, ADDR_ATTR, 8'h54);
    pulse(mwr);
    bus(0, ADDR_ATTR, 8'h55);
    chk(32'(advances), 32'h0000_0002);
    {par, on} = {8'h15, 1'b1};
    pulse(cmd);
    vis(6'h13);
    bus(0, ADDR_ATTR, 8'h15);
    on = 1'b0;
    pulse(cmd);
    vis(6'h20);
    $display("test memory and command done");
    bus(1, ADDR_DISP_EN, 8'h01);
    ps = 1'b1;
    vis(6'h20);
    bus(1, ADDR_DISP_EN, 8'h01);
    ps = 1'b0;
    bus(0, ADDR_DISP_EN, 8'h00);
    bus(1, ADDR_DISP_EN, 8'h01);
    bus(0, ADDR_DISP_EN, 8'h01);
    chk(32'(expq.size()), 32'h0000_0000);
    $display("test power save done");
    wrap_up();
  end
endmodule // testbench

`default_nettype wire
